// ===== include/dpmb_pkg.sv
// shared constants and types of the dual-port message buffer
package dpmb_pkg;

  // command codes
  localparam logic [7:0] OP_CFG_WRITE = 8'h11;
  localparam logic [7:0] OP_CFG_READ  = 8'h22;
  localparam logic [7:0] OP_BUF_WRITE = 8'h33;
  localparam logic [7:0] OP_BUF_READ  = 8'h44;

  // bridge_configuration field positions
  localparam int CFG_FUNC_SELECT = 0;
  localparam int CFG_PORT_A_FOE  = 1;
  localparam int CFG_PORT_B_FOE  = 2;
  localparam int CFG_PASSTHROUGH = 3;
  localparam int CFG_QUIET       = 4;
  localparam int CFG_PULLUP      = 5;
  localparam int CFG_BITS        = 6;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // message buffer geometry
  localparam int         BUF_BYTES  = 8;
  localparam int         COUNT_W    = 4;
  localparam logic [7:0] MAX_COUNT  = 8'h08;
  localparam logic [3:0] COUNT_ZERO = 4'h0;

  // crc-16, reflected form of x16+x15+x2+1, zero start
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
  localparam logic [15:0] CRC_INIT      = 16'h0000;

  // response fifo geometry
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;

  // command engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_PARAM  = 6'h02,
    ST_DATA   = 6'h04,
    ST_BODY   = 6'h08,
    ST_CRC_LO = 6'h10,
    ST_CRC_HI = 6'h20
  } dpmb_state_e;

endpackage

// ===== design/dpmb_top.sv
// command engine, shared message buffer and response fifo of the two-port bridge

// first-in first-out store of response bytes
module dpmb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // full when pointers differ only in the wrap bit
  wire empty   = (wr_ptr == rd_ptr);
  wire full    = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire do_push = in_valid && !full;
  wire do_pop  = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // pointer update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage write
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// command engine serving both single-wire ports
module dpmb_top #(
  parameter int FIFO_DEPTH = dpmb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // primary_link_port byte side
  input  wire logic       a_frame_reset,
  input  wire logic       a_rx_valid,
  input  wire logic [7:0] a_rx_data,
  // secondary_link_port byte side
  input  wire logic       b_frame_reset,
  input  wire logic       b_rx_valid,
  input  wire logic [7:0] b_rx_data,
  // token owner, high when the secondary port holds it
  input  wire logic       token_at_secondary,
  // response bytes toward the ports
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_to_secondary,
  input  wire logic       tx_ready,
  // configuration state
  output logic            func_select,
  output logic            port_a_flag_output_enable,
  output logic            port_b_flag_output_enable,
  output logic            passthrough_enable,
  output logic            quiet_enable,
  output logic            pullup_enable,
  // buffer ownership flags
  output logic            written_by_port_a,
  output logic            written_by_port_b
);

  // one crc-16 byte step, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (c[0] ^ d[i])
        c = (c >> 1) ^ dpmb_pkg::CRC_POLY_REFL;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  dpmb_pkg::dpmb_state_e    state;
  logic [7:0]               cmd;
  logic                     active_b;
  logic                     armed_a;
  logic                     armed_b;
  logic [15:0]              crc;
  logic [3:0]               idx;
  logic [3:0]               wcount;
  logic [3:0]               byte_count;
  logic [7:0]               buffer [dpmb_pkg::BUF_BYTES];
  logic [7:0]               stage  [dpmb_pkg::BUF_BYTES];

  // receive selection: idle takes a freshly armed port, else only the active one
  wire st_idle  = (state == dpmb_pkg::ST_IDLE);
  wire st_param = (state == dpmb_pkg::ST_PARAM);
  wire st_data  = (state == dpmb_pkg::ST_DATA);
  wire st_body  = (state == dpmb_pkg::ST_BODY);
  wire st_lo    = (state == dpmb_pkg::ST_CRC_LO);
  wire st_hi    = (state == dpmb_pkg::ST_CRC_HI);
  wire take_a   = a_rx_valid && (st_idle ? armed_a : !active_b);
  wire take_b   = b_rx_valid && (st_idle ? (armed_b && !take_a) : active_b);
  wire rx_take  = (take_a || take_b) && (st_idle || st_param || st_data);
  wire [7:0] rx_byte = take_a ? a_rx_data : b_rx_data;
  wire rx_from_b     = st_idle ? !take_a : active_b;
  wire abort         = !st_idle && (active_b ? b_frame_reset : a_frame_reset);

  // a buffer write commits only if the writing port holds the token; configuration writes do not check it
  wire holder = (active_b == token_at_secondary);

  // configuration byte as read back
  wire [7:0] cfg_byte = {2'b00, pullup_enable, quiet_enable, passthrough_enable,
                         port_b_flag_output_enable, port_a_flag_output_enable,
                         func_select};

  // body byte and length of a read response
  wire [7:0] len_byte  = {4'h0, byte_count};
  wire [3:0] body_len  = (cmd == dpmb_pkg::OP_CFG_READ) ? 4'h1 : byte_count + 4'h1;
  wire [2:0] buf_sel   = 3'(idx - 4'h1);
  wire [7:0] body_byte = (cmd == dpmb_pkg::OP_CFG_READ) ? cfg_byte :
                         (idx == 4'h0) ? len_byte : buffer[buf_sel];

  // outgoing byte and fifo handshake
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [8:0]  fifo_out_data;
  wire        sending  = st_body || st_lo || st_hi;
  wire [7:0]  out_byte = st_body ? body_byte : st_lo ? ~crc[7:0] : ~crc[15:8];
  wire        send_ok  = sending && fifo_in_ready && !abort;
  wire        drain    = !tx_valid || tx_ready;
  wire        last_data = (idx == wcount - 4'h1);

  // response fifo between engine and port drivers
  dpmb_fifo #(
    .WIDTH (dpmb_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (sending && !abort),
    .in_ready  (fifo_in_ready),
    .in_data   ({active_b, out_byte}),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  // output stage so the port side sees flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_valid        <= 1'b0;
      tx_data         <= 8'h00;
      tx_to_secondary <= 1'b0;
    end
    else if (drain)
    begin
      tx_valid        <= fifo_out_valid;
      tx_data         <= fifo_out_data[7:0];
      tx_to_secondary <= fifo_out_data[8];
    end
  end

  // ports are armed by their own frame reset, disarmed once a command starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_a <= 1'b0;
      armed_b <= 1'b0;
    end
    else
    begin
      if (a_frame_reset)
        armed_a <= 1'b1;
      else if (rx_take && st_idle && take_a)
        armed_a <= 1'b0;
      if (b_frame_reset)
        armed_b <= 1'b1;
      else if (rx_take && st_idle && !take_a)
        armed_b <= 1'b0;
    end
  end

  // command sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= dpmb_pkg::ST_IDLE;
      cmd      <= 8'h00;
      active_b <= 1'b0;
      crc      <= dpmb_pkg::CRC_INIT;
      idx      <= 4'h0;
      wcount   <= 4'h0;
    end
    else if (abort)
      state <= dpmb_pkg::ST_IDLE;
    else
    begin
      case (state)
        dpmb_pkg::ST_IDLE:
        begin
          if (rx_take)
          begin
            cmd      <= rx_byte;
            active_b <= rx_from_b;
            crc      <= crc_step(dpmb_pkg::CRC_INIT, rx_byte);
            idx      <= 4'h0;
            if (rx_byte == dpmb_pkg::OP_CFG_WRITE || rx_byte == dpmb_pkg::OP_BUF_WRITE)
              state <= dpmb_pkg::ST_PARAM;
            else if (rx_byte == dpmb_pkg::OP_CFG_READ || rx_byte == dpmb_pkg::OP_BUF_READ)
              state <= dpmb_pkg::ST_BODY;
          end
        end
        dpmb_pkg::ST_PARAM:
        begin
          if (rx_take)
          begin
            crc    <= crc_step(crc, rx_byte);
            wcount <= rx_byte[3:0];
            if (cmd == dpmb_pkg::OP_CFG_WRITE)
              state <= dpmb_pkg::ST_CRC_LO;
            else if (rx_byte > dpmb_pkg::MAX_COUNT)
              state <= dpmb_pkg::ST_IDLE;
            else if (rx_byte[3:0] == dpmb_pkg::COUNT_ZERO)
              state <= dpmb_pkg::ST_CRC_LO;
            else
              state <= dpmb_pkg::ST_DATA;
          end
        end
        dpmb_pkg::ST_DATA:
        begin
          if (rx_take)
          begin
            crc <= crc_step(crc, rx_byte);
            idx <= idx + 4'h1;
            if (last_data)
              state <= dpmb_pkg::ST_CRC_LO;
          end
        end
        dpmb_pkg::ST_BODY:
        begin
          if (send_ok)
          begin
            crc <= crc_step(crc, body_byte);
            idx <= idx + 4'h1;
            if (idx == body_len - 4'h1)
              state <= dpmb_pkg::ST_CRC_LO;
          end
        end
        dpmb_pkg::ST_CRC_LO:
        begin
          if (send_ok)
            state <= dpmb_pkg::ST_CRC_HI;
        end
        dpmb_pkg::ST_CRC_HI:
        begin
          if (send_ok)
            state <= dpmb_pkg::ST_IDLE;
        end
        default:
          state <= dpmb_pkg::ST_IDLE;
      endcase
    end
  end

  // configuration register, loaded by the configuration write parameter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {pullup_enable, quiet_enable, passthrough_enable, port_b_flag_output_enable,
       port_a_flag_output_enable, func_select} <= dpmb_pkg::CFG_RESET;
    end
    else if (st_param && rx_take && !abort && cmd == dpmb_pkg::OP_CFG_WRITE)
    begin
      func_select               <= rx_byte[dpmb_pkg::CFG_FUNC_SELECT];
      port_a_flag_output_enable <= rx_byte[dpmb_pkg::CFG_PORT_A_FOE];
      port_b_flag_output_enable <= rx_byte[dpmb_pkg::CFG_PORT_B_FOE];
      passthrough_enable        <= rx_byte[dpmb_pkg::CFG_PASSTHROUGH];
      quiet_enable              <= rx_byte[dpmb_pkg::CFG_QUIET];
      pullup_enable             <= rx_byte[dpmb_pkg::CFG_PULLUP];
    end
  end

  // write commit strobes
  wire zero_write = st_param && rx_take && !abort && cmd == dpmb_pkg::OP_BUF_WRITE &&
                    rx_byte == 8'h00 && holder;
  wire full_write = st_data && rx_take && !abort && last_data && holder;

  // ownership flags and stored count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      written_by_port_a <= 1'b0;
      written_by_port_b <= 1'b0;
      byte_count        <= dpmb_pkg::COUNT_ZERO;
    end
    else if (zero_write)
    begin
      written_by_port_a <= 1'b0;
      written_by_port_b <= 1'b0;
      byte_count        <= dpmb_pkg::COUNT_ZERO;
    end
    else if (full_write)
    begin
      written_by_port_a <= !active_b;
      written_by_port_b <= active_b;
      byte_count        <= wcount;
    end
  end

  // staging keeps the live buffer intact until the last byte arrives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < dpmb_pkg::BUF_BYTES; i++)
      begin
        stage[i]  <= 8'h00;
        buffer[i] <= 8'h00;
      end
    end
    else if (st_data && rx_take && !abort)
    begin
      stage[idx[2:0]] <= rx_byte;
      if (full_write)
      begin
        for (int i = 0; i < dpmb_pkg::BUF_BYTES; i++)
          buffer[i] <= (i == int'(idx)) ? rx_byte : stage[i];
      end
    end
  end

endmodule

// ===== verification/dpmb_properties.sv
// concurrent checks on the ports of the dual-port message buffer
module dpmb_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // received bytes and token
  input wire logic       a_rx_valid,
  input wire logic       b_rx_valid,
  input wire logic       token_at_secondary,
  // response bytes
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_to_secondary,
  input wire logic       tx_ready,
  // configuration and flags
  input wire logic       func_select,
  input wire logic       port_a_flag_output_enable,
  input wire logic       port_b_flag_output_enable,
  input wire logic       passthrough_enable,
  input wire logic       quiet_enable,
  input wire logic       pullup_enable,
  input wire logic       written_by_port_a,
  input wire logic       written_by_port_b
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a response byte offered but not yet taken by the port driver
  sequence held_byte;
    tx_valid && !tx_ready;
  endsequence

  // any byte arriving on either port one cycle back
  sequence byte_came;
    $past(a_rx_valid) || $past(b_rx_valid);
  endsequence

  byte_hold_a: assert property (held_byte |=> tx_valid && $stable(tx_data)
    && $stable(tx_to_secondary)) else $error("response byte changed before accept");
  flags_exclusive_a: assert property (!(written_by_port_a && written_by_port_b))
    else $error("both written flags set");
  flag_cause_a: assert property ($changed({written_by_port_a, written_by_port_b})
    |-> byte_came) else $error("flags changed without a received byte");
  flag_a_owner_a: assert property ($rose(written_by_port_a)
    |-> $past(a_rx_valid) && !$past(token_at_secondary)) else $error("flag a set wrongly");
  flag_b_owner_a: assert property ($rose(written_by_port_b)
    |-> $past(b_rx_valid) && $past(token_at_secondary)) else $error("flag b set wrongly");
  config_cause_a: assert property ($changed({func_select, port_a_flag_output_enable,
    port_b_flag_output_enable, passthrough_enable, quiet_enable, pullup_enable})
    |-> byte_came) else $error("configuration changed without a received byte");
  answer_port_a: assert property ($rose(tx_valid) |-> (tx_to_secondary ?
    $past(b_rx_valid, 3) : $past(a_rx_valid, 3))) else $error("answer port or delay wrong");
  reset_clear_a: assert property ($rose(rst_n) |-> !written_by_port_a
    && !written_by_port_b && !tx_valid) else $error("state not clear after reset");
endmodule

bind dpmb_top dpmb_properties u_props (.clk, .rst_n, .a_rx_valid, .b_rx_valid,
  .token_at_secondary, .tx_valid, .tx_data, .tx_to_secondary, .tx_ready, .func_select,
  .port_a_flag_output_enable, .port_b_flag_output_enable, .passthrough_enable,
  .quiet_enable, .pullup_enable, .written_by_port_a, .written_by_port_b);

// ===== verification/dpmb_host_model.sv
// host-side port driver model: takes response bytes promptly or with stalls
module dpmb_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // response bytes from the block
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_to_secondary,
  output logic            tx_ready,
  // pacing control
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] got_q [$];
  logic [1:0] pace;

  // accept on handshake; in slow mode only one cycle in four is ready
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pace     <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
        got_q.push_back({tx_to_secondary, tx_data}); // arrival order kept
      pace     <= pace + 2'h1;
      tx_ready <= !slow || (pace == 2'h3);
    end
  end
endmodule

// ===== verification/dual_port_message_buffer_bench.sv
// self-checking bench of the dual-port message buffer
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_port_message_buffer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] dpmb_bytes_t [$];
  int          num_errors = 0;
  int          samples_checked = 0;
  logic        clk = 1'b0;
  logic        rst_n, a_frame_reset, a_rx_valid, b_frame_reset, b_rx_valid;
  logic        token_at_secondary, tx_valid, tx_to_secondary, tx_ready, slow;
  logic [7:0]  a_rx_data, b_rx_data, tx_data;
  logic        func_select, port_a_flag_output_enable, port_b_flag_output_enable;
  logic        passthrough_enable, quiet_enable, pullup_enable;
  logic        written_by_port_a, written_by_port_b;
  logic [5:0]  cfg_bits;
  dpmb_bytes_t full_buf;

  always #2.5 clk = ~clk;

  // configuration outputs gathered in register bit order
  assign cfg_bits = {pullup_enable, quiet_enable, passthrough_enable,
                     port_b_flag_output_enable, port_a_flag_output_enable, func_select};

  dpmb_top dut (.clk, .rst_n, .a_frame_reset, .a_rx_valid, .a_rx_data, .b_frame_reset,
    .b_rx_valid, .b_rx_data, .token_at_secondary, .tx_valid, .tx_data, .tx_to_secondary,
    .tx_ready, .func_select, .port_a_flag_output_enable, .port_b_flag_output_enable,
    .passthrough_enable, .quiet_enable, .pullup_enable, .written_by_port_a,
    .written_by_port_b);
  dpmb_host_model host (.clk, .rst_n, .tx_valid, .tx_data, .tx_to_secondary, .tx_ready,
    .slow);

  // prints counts and verdict, ends the run
  task automatic final_report;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // frame reset, then the command bytes back to back on one port
  task automatic send(input logic port, input dpmb_bytes_t b);
    @(posedge clk) #1 {a_frame_reset, b_frame_reset} = port ? 2'b01 : 2'b10;
    foreach (b[i])
    begin
      @(posedge clk) #1 {a_frame_reset, b_frame_reset, a_rx_valid, b_rx_valid} =
        port ? 4'b0001 : 4'b0010;
      a_rx_data = b[i];
      b_rx_data = b[i];
    end
    @(posedge clk) #1 {a_frame_reset, b_frame_reset, a_rx_valid, b_rx_valid} = 4'h0;
  endtask

  // waits for the answer: last nb bytes of s, then inverted crc over s
  task automatic expect_resp(input logic port, input dpmb_bytes_t s, input int nb);
    logic [15:0] c;
    dpmb_bytes_t e;
    int          k;
    c = 16'h0000;
    foreach (s[i])
      for (int j = 0; j < 8; j++)
        c = (c >> 1) ^ ((c[0] ^ s[i][j]) ? 16'ha001 : 16'h0000);
    for (int i = s.size() - nb; i < s.size(); i++)
      e.push_back(s[i]);
    e.push_back(~c[7:0]);
    e.push_back(~c[15:8]);
    k = 0;
    while (host.got_q.size() < e.size() && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    if (host.got_q.size() < e.size())
    begin
      num_errors++;
      final_report;
    end
    repeat (6) @(posedge clk);
    `CHK(host.got_q.size(), e.size())
    foreach (e[i])
      `CHK(host.got_q[i], {port, e[i]})
    host.got_q.delete();
  endtask

  // configuration written from port a, read back from port b
  task automatic t_config;
    logic [7:0] v;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 8'h2a : 8'h15;
      send(1'b0, '{8'h11, v});
      expect_resp(1'b0, '{8'h11, v}, 0);
      `CHK(cfg_bits, v[5:0])
      send(1'b1, '{8'h22});
      expect_resp(1'b1, '{8'h22, v}, 1);
    end
  endtask

  // full eight-byte write from a, read from b with a stalling driver
  task automatic t_write_read;
    full_buf = '{8'h33, 8'h08, 8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab, 8'hcd, 8'hef};
    @(posedge clk) #1 slow = 1'b1;
    send(1'b0, full_buf);
    expect_resp(1'b0, full_buf, 0);
    `CHK({written_by_port_a, written_by_port_b}, 2'b10)
    full_buf[0] = 8'h44;
    send(1'b1, '{8'h44});
    expect_resp(1'b1, full_buf, 9);
    @(posedge clk) #1 slow = 1'b0;
  endtask

  // write without token, then oversize count: buffer untouched
  task automatic t_refuse;
    send(1'b1, '{8'h33, 8'h03, 8'h5a, 8'h5b, 8'h5c});
    expect_resp(1'b1, '{8'h33, 8'h03, 8'h5a, 8'h5b, 8'h5c}, 0);
    send(1'b0, '{8'h33, 8'h09});
    repeat (20) @(posedge clk);
    `CHK(host.got_q.size(), 0)
    `CHK({written_by_port_a, written_by_port_b}, 2'b10)
    send(1'b0, '{8'h44});
    expect_resp(1'b0, full_buf, 9);
  endtask

  // secondary holds the token and writes two bytes, then a zero count
  task automatic t_b_write_zero;
    @(posedge clk) #1 token_at_secondary = 1'b1;
    send(1'b1, '{8'h33, 8'h02, 8'hc3, 8'h3c});
    expect_resp(1'b1, '{8'h33, 8'h02, 8'hc3, 8'h3c}, 0);
    `CHK({written_by_port_a, written_by_port_b}, 2'b01)
    send(1'b0, '{8'h44});
    expect_resp(1'b0, '{8'h44, 8'h02, 8'hc3, 8'h3c}, 3);
    send(1'b1, '{8'h33, 8'h00}); // count in low nibble only
    expect_resp(1'b1, '{8'h33, 8'h00}, 0);
    `CHK({written_by_port_a, written_by_port_b}, 2'b00)
    send(1'b0, '{8'h44});
    expect_resp(1'b0, '{8'h44, 8'h00}, 1);
  endtask

  // write cut by a frame reset keeps the buffer; reset in mid-run clears flags and config
  task automatic t_abort_reset;
    send(1'b1, '{8'h33, 8'h01, 8'h77});
    expect_resp(1'b1, '{8'h33, 8'h01, 8'h77}, 0);
    `CHK({written_by_port_a, written_by_port_b}, 2'b01)
    send(1'b1, '{8'h33, 8'h02, 8'haa});
    send(1'b1, '{8'h44});
    expect_resp(1'b1, '{8'h44, 8'h01, 8'h77}, 2);
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK({written_by_port_a, written_by_port_b}, 2'b00)
    `CHK(cfg_bits, 6'h00)
    send(1'b0, '{8'h44});
    expect_resp(1'b0, '{8'h44, 8'h00}, 1);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    {a_frame_reset, a_rx_valid, b_frame_reset, b_rx_valid} = 4'h0;
    a_rx_data = 8'h00;
    b_rx_data = 8'h00;
    token_at_secondary = 1'b0;
    slow = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_config;
    t_write_read;
    t_refuse;
    t_b_write_zero;
    t_abort_reset;
    final_report;
  end
endmodule
